// File: hw/alarm_relay_defines.vh
// constants for the process alarm relay block
// assumes a 100 MHz system clock and a synchronous active-high reset
`ifndef ALARM_RELAY_DEFINES_VH
`define ALARM_RELAY_DEFINES_VH

// clock and one-second time base
`define CLK_HZ          100000000
`define SEC_CYCLES      (`CLK_HZ / 1)

// apb register byte offsets
`define REG_CTRL        12'h000
`define REG_LIMITS      12'h004
`define REG_HYST        12'h008
`define REG_STATUS      12'h00C
`define REG_EVENT       12'h010

// control register fields
`define CTRL_HIGH_EN    0
`define CTRL_LOW_EN     1
`define CTRL_SUPPRESS   2
`define CTRL_PULSE      3
`define CTRL_OPEN       4
`define CTRL_BEEPMODE   5
`define CTRL_FAHR       6
`define CTRL_PLEN_LSB   8
`define CTRL_RESET      32'h0000_0500

// pulse length range in seconds
`define PULSE_MIN       7'h01
`define PULSE_MAX       7'h64

// event register command bits (write one to start)
`define EV_STEP_DONE    0
`define EV_STEP_START   1
`define EV_PROG_END     2
`define EV_BOIL_EVENT   3
`define EV_BOIL_START   4
`define EV_BOIL_STOP    5

// fault display alternates
`define FAULT_F_VALUE   10'h3A4
`define FAULT_C_VALUE   10'h1F4

`endif

// File: hw/alarm_relay.v
// process alarm relay logic: alarm compare, suppression, relay action, beeper, fault display
// assumes an apb master on CLK_IN, a new temperature sample strobe and a fault input
//
// Contract
// - with suppression on, relay stays inactive after power-up in low zone
// - suppression applies only with low limit on and never above low plus band
// - once above low plus band, suppression ends for good
// - high alarm sets above high limit, clears below high minus band
// - low alarm sets below low limit, clears above low plus band
// - each limit may be off; relay follows only enabled limits
// - with both limits on, low limit at or above high limit keeps alarm asserted
// - pulse lasts programmed whole seconds, 1 to 100; counted on the free-running second tick, so the first second is partial
// - step done sounds four 2 s tones with 1,2,1 s pauses
// - step timer start sounds three 1 s tones
// - program end sounds eight 5 s tones and flashes end
// - boil event repeats four-tone pattern until alert time elapses
// - boil first timer start sounds three 1 s tones
// - sensor fault alternates fault message with 932 F or 500 C
// - non-latching relay follows alarm condition
// - pulse action fires once per alarm onset for preset time
// - close polarity closes on alarm, open polarity opens on alarm
// - buzzer-follow mode makes relay active exactly while buzzer sounds
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"

module alarm_relay #(
	parameter SEC_CYCLES = `SEC_CYCLES
) (
	// clock and reset
	input  wire        CLK_IN,
	input  wire        RESET_IN,
	// apb slave
	input  wire        PSEL_IN,
	input  wire        PENABLE_IN,
	input  wire        PWRITE_IN,
	input  wire [11:0] PADDR_IN,
	input  wire [31:0] PWDATA_IN,
	output wire [31:0] PRDATA_OUT,
	output wire        PREADY_OUT,
	output wire        PSLVERR_OUT,
	// temperature readout
	input  wire [9:0]  TEMP_IN,
	input  wire        TEMP_VALID_IN,
	input  wire        SENSOR_FAULT_IN,
	// relay, buzzer, display
	output reg         RELAY_CLOSED_OUT,
	output reg         BUZZER_OUT,
	output reg         END_FLASH_OUT,
	output reg         FAULT_MSG_OUT,
	output reg  [9:0]  FAULT_VALUE_OUT
);

	// beeper pattern codes
	localparam PAT_NONE  = 2'h0;
	localparam PAT_FOUR  = 2'h1;
	localparam PAT_THREE = 2'h2;
	localparam PAT_EIGHT = 2'h3;

	// configuration
	reg  [31:0] ctrl;
	reg  [9:0]  high_alarm_limit;
	reg  [9:0]  low_alarm_limit;
	reg  [9:0]  hysteresis_band;
	reg  [15:0] alert_secs;
	// alarm state
	reg         high_alarm;
	reg         low_alarm;
	reg         alarm_suppress;
	reg         alarm_prev;
	reg         pulse_on;
	reg  [6:0]  pulse_left;
	// time base and beeper
	reg  [31:0] sec_count;
	reg  [1:0]  pattern;
	reg  [4:0]  slot;
	reg  [2:0]  slot_sec;
	reg         boil_repeat;
	reg  [15:0] alert_left;
	reg         end_flash;
	reg         flash_phase;

	wire        high_en        = ctrl[`CTRL_HIGH_EN];
	wire        low_en         = ctrl[`CTRL_LOW_EN];
	wire        pulse_action   = ctrl[`CTRL_PULSE];
	wire        open_on_alarm  = ctrl[`CTRL_OPEN];
	wire        beep_mode      = ctrl[`CTRL_BEEPMODE];
	wire [6:0]  pulse_length   = ctrl[`CTRL_PLEN_LSB+6:`CTRL_PLEN_LSB];
	wire        sec_tick       = (sec_count == SEC_CYCLES - 1);
	wire        wr             = PSEL_IN & PENABLE_IN & PWRITE_IN;
	// band is added to the sample, so a band wider than the high limit cannot wrap
	wire [10:0] temp_plus_band = {1'b0, TEMP_IN} + {1'b0, hysteresis_band};
	wire [10:0] low_release    = {1'b0, low_alarm_limit} + {1'b0, hysteresis_band};
	wire        inverted       = low_en & high_en & (low_alarm_limit >= high_alarm_limit);

	// pattern table: returns {tone, length in seconds} for a slot of a pattern
	function [5:0] slot_info;
		input [1:0] pat;
		input [4:0] idx;
		begin
			case (pat)
				// four tones: 2 on,1 off,2 on,2 off,2 on,1 off,2 on,2 off
				PAT_FOUR: begin
					case (idx)
						5'h00: slot_info = {1'b1, 5'h02};
						5'h01: slot_info = {1'b0, 5'h01};
						5'h02: slot_info = {1'b1, 5'h02};
						5'h03: slot_info = {1'b0, 5'h02};
						5'h04: slot_info = {1'b1, 5'h02};
						5'h05: slot_info = {1'b0, 5'h01};
						5'h06: slot_info = {1'b1, 5'h02};
						5'h07: slot_info = {1'b0, 5'h02}; // gap keeps boil repeats apart
						default: slot_info = {1'b0, 5'h00};
					endcase
				end
				// three 1 s tones, 1 s gaps
				PAT_THREE: slot_info = (idx < 5'h05) ? {~idx[0], 5'h01} : {1'b0, 5'h00};
				// eight 5 s tones, 2 s gaps
				PAT_EIGHT: slot_info = (idx < 5'h0F) ? (idx[0] ? {1'b0, 5'h02} : {1'b1, 5'h05})
				                                     : {1'b0, 5'h00};
				default: slot_info = {1'b0, 5'h00};
			endcase
		end
	endfunction

	wire [5:0] cur_slot = slot_info(pattern, slot);
	wire       tone     = (pattern != PAT_NONE) & cur_slot[5];
	wire       slot_end = sec_tick & ({2'h0, slot_sec} + 5'h01 >= cur_slot[4:0]);
	wire       pat_done = slot_info(pattern, slot + 5'h01) == 6'h00;

	// suppression gate: option on, low limit on, never above low plus band since reset
	wire suppress_low = ctrl[`CTRL_SUPPRESS] & low_en & alarm_suppress;
	// combined alarm condition; only enabled limits count
	wire alarm_cond = inverted | (high_en & high_alarm)
	                | (low_en & low_alarm & ~suppress_low);
	reg  relay_active;

	// apb slave: zero wait, unmapped reads zero, no error
	reg [31:0] rdata;
	always @* begin
		case (PADDR_IN)
			`REG_CTRL:   rdata = ctrl;
			`REG_LIMITS: rdata = {6'h00, high_alarm_limit, 6'h00, low_alarm_limit};
			`REG_HYST:   rdata = {alert_secs, 6'h00, hysteresis_band};
			`REG_STATUS: rdata = {25'h0, relay_active, tone, alarm_suppress, pulse_on,
			                      alarm_cond, low_alarm, high_alarm};
			default:     rdata = 32'h0000_0000;
		endcase
	end
	assign PRDATA_OUT  = rdata;
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = 1'b0;

	// register writes; pulse length clamped to its legal range
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			ctrl             <= `CTRL_RESET;
			high_alarm_limit <= 10'h000;
			low_alarm_limit  <= 10'h000;
			hysteresis_band  <= 10'h003;
			alert_secs       <= 16'h003C;
		end else if (wr) begin
			case (PADDR_IN)
				`REG_CTRL: begin
					ctrl <= PWDATA_IN;
					if (PWDATA_IN[`CTRL_PLEN_LSB+6:`CTRL_PLEN_LSB] < `PULSE_MIN)
						ctrl[`CTRL_PLEN_LSB+6:`CTRL_PLEN_LSB] <= `PULSE_MIN;
					else if (PWDATA_IN[`CTRL_PLEN_LSB+6:`CTRL_PLEN_LSB] > `PULSE_MAX)
						ctrl[`CTRL_PLEN_LSB+6:`CTRL_PLEN_LSB] <= `PULSE_MAX;
				end
				`REG_LIMITS: begin
					high_alarm_limit <= PWDATA_IN[25:16];
					low_alarm_limit  <= PWDATA_IN[9:0];
				end
				`REG_HYST: begin
					hysteresis_band <= PWDATA_IN[9:0];
					alert_secs      <= PWDATA_IN[31:16];
				end
				default: ;
			endcase
		end
	end

	// hysteresis comparators, evaluated only on a new sample
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			high_alarm     <= 1'b0;
			low_alarm      <= 1'b0;
			alarm_suppress <= 1'b1;
		end else if (TEMP_VALID_IN) begin
			if (TEMP_IN > high_alarm_limit)
				high_alarm <= 1'b1;
			else if (temp_plus_band < {1'b0, high_alarm_limit})
				high_alarm <= 1'b0;
			if (TEMP_IN < low_alarm_limit)
				low_alarm <= 1'b1;
			else if ({1'b0, TEMP_IN} > low_release) begin
				low_alarm      <= 1'b0;
				alarm_suppress <= 1'b0;
			end
		end
	end

	// one-second time base, free running
	always @(posedge CLK_IN) begin
		if (RESET_IN || sec_tick)
			sec_count <= 32'h0;
		else
			sec_count <= sec_count + 32'h1;
	end

	// pulse action: one pulse per onset, rearmed only after release
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			alarm_prev <= 1'b0;
			pulse_on   <= 1'b0;
			pulse_left <= 7'h00;
		end else begin
			alarm_prev <= alarm_cond;
			if (alarm_cond && !alarm_prev) begin
				pulse_on   <= 1'b1;
				pulse_left <= pulse_length;
			end else if (pulse_on && sec_tick) begin
				pulse_left <= pulse_left - 7'h01;
				if (pulse_left == 7'h01)
					pulse_on <= 1'b0;
			end
		end
	end

	// beeper sequencer; a new event restarts the pattern
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			pattern     <= PAT_NONE;
			slot        <= 5'h00;
			slot_sec    <= 3'h0;
			boil_repeat <= 1'b0;
			alert_left  <= 16'h0000;
			end_flash   <= 1'b0;
		end else if (wr && PADDR_IN == `REG_EVENT) begin
			slot     <= 5'h00;
			slot_sec <= 3'h0;
			// clear first, so an end event in the same write wins
			if (PWDATA_IN[`EV_BOIL_STOP])
				end_flash <= 1'b0;
			if (PWDATA_IN[`EV_STEP_DONE]) begin
				pattern     <= PAT_FOUR;
				boil_repeat <= 1'b0;
			end else if (PWDATA_IN[`EV_STEP_START] || PWDATA_IN[`EV_BOIL_START]) begin
				pattern     <= PAT_THREE;
				boil_repeat <= 1'b0;
			end else if (PWDATA_IN[`EV_PROG_END]) begin
				pattern     <= PAT_EIGHT;
				end_flash   <= 1'b1;
				boil_repeat <= 1'b0;
			end else if (PWDATA_IN[`EV_BOIL_EVENT]) begin
				pattern     <= PAT_FOUR;
				boil_repeat <= 1'b1;
				alert_left  <= alert_secs;
			end
		end else begin
			// alert duration counts down; reaching zero stops the repeat
			if (boil_repeat && sec_tick) begin
				if (alert_left <= 16'h0001) begin
					boil_repeat <= 1'b0;
					pattern     <= PAT_NONE;
				end
				alert_left <= alert_left - 16'h0001;
			end
			if (pattern != PAT_NONE && slot_end) begin
				slot_sec <= 3'h0;
				if (pat_done) begin
					slot <= 5'h00;
					if (!boil_repeat)
						pattern <= PAT_NONE;
				end else
					slot <= slot + 5'h01;
			end else if (pattern != PAT_NONE && sec_tick)
				slot_sec <= slot_sec + 3'h1;
		end
	end

	// relay selection: buzzer follow, pulse or follow the alarm
	always @* begin
		if (beep_mode)
			relay_active = tone;
		else if (pulse_action)
			relay_active = pulse_on;
		else
			relay_active = alarm_cond;
	end

	// registered outputs; fault display alternates once a second
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			RELAY_CLOSED_OUT <= 1'b0;
			BUZZER_OUT       <= 1'b0;
			END_FLASH_OUT    <= 1'b0;
			FAULT_MSG_OUT    <= 1'b0;
			FAULT_VALUE_OUT  <= 10'h000;
			flash_phase      <= 1'b0;
		end else begin
			RELAY_CLOSED_OUT <= relay_active ^ open_on_alarm;
			BUZZER_OUT       <= tone;
			if (sec_tick)
				flash_phase <= ~flash_phase;
			END_FLASH_OUT   <= end_flash & flash_phase;
			FAULT_MSG_OUT   <= SENSOR_FAULT_IN & ~flash_phase;
			FAULT_VALUE_OUT <= (SENSOR_FAULT_IN & flash_phase)
			                   ? (ctrl[`CTRL_FAHR] ? `FAULT_F_VALUE : `FAULT_C_VALUE)
			                   : 10'h000;
		end
	end

endmodule // alarm_relay

// File: bench/alarm_relay_props.sv
// port checker for the alarm relay: apb answer, alarm timing, beeper follow, fault display
// assumes binding to alarm_relay; config is rebuilt by snooping completed apb writes
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"
module alarm_relay_props (
	input logic        CLK_IN, RESET_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT,
	input logic [11:0] PADDR_IN,
	input logic [31:0] PWDATA_IN, PRDATA_OUT,
	input logic [9:0]  TEMP_IN, FAULT_VALUE_OUT,
	input logic        TEMP_VALID_IN, SENSOR_FAULT_IN, RELAY_CLOSED_OUT, BUZZER_OUT, FAULT_MSG_OUT
);
	logic [6:0]  ctl;
	logic [10:0] hi, lo, band;
	// shadow config; one bit wider so limit plus band cannot wrap
	always_ff @(posedge CLK_IN)
		if (RESET_IN) begin
			ctl <= 7'h00;
			hi <= 11'h000;
			lo <= 11'h000;
			band <= 11'h003;
		end else if (PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT) begin
			if (PADDR_IN == `REG_CTRL)
				ctl <= PWDATA_IN[6:0];
			if (PADDR_IN == `REG_LIMITS) begin
				hi <= {1'b0, PWDATA_IN[25:16]};
				lo <= {1'b0, PWDATA_IN[9:0]};
			end
			if (PADDR_IN == `REG_HYST)
				band <= {1'b0, PWDATA_IN[9:0]};
		end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// samples in plain follow mode, close polarity, one limit only
	sequence high_sample;
		TEMP_VALID_IN && ctl == 7'h01 && {1'b0, TEMP_IN} > hi;
	endsequence
	sequence low_clear_sample;
		TEMP_VALID_IN && ctl == 7'h02 && {1'b0, TEMP_IN} > lo + band;
	endsequence
	a_ready_high: assert property (PREADY_OUT) else $error("pready low");
	a_reset_quiet: assert property (disable iff (1'b0) RESET_IN |=> !RELAY_CLOSED_OUT
		&& !BUZZER_OUT && !FAULT_MSG_OUT) else $error("outputs not cleared");
	a_high_trip: assert property (high_sample |=> ##1 RELAY_CLOSED_OUT)
		else $error("relay missed high alarm");
	a_low_release: assert property (low_clear_sample |=> ##1 !RELAY_CLOSED_OUT)
		else $error("relay held after low release");
	a_beep_follow: assert property ($rose(BUZZER_OUT) && ctl[5] |->
		##[0:1] RELAY_CLOSED_OUT == !ctl[4]) else $error("relay not following tone");
	a_fault_units: assert property (FAULT_VALUE_OUT != 10'h000 && $stable(ctl[6]) |->
		FAULT_VALUE_OUT == (ctl[6] ? `FAULT_F_VALUE : `FAULT_C_VALUE)) else $error("bad units");
	a_fault_phase: assert property (!(FAULT_MSG_OUT && FAULT_VALUE_OUT != 10'h000))
		else $error("fault message and value together");
	a_fault_idle: assert property (!SENSOR_FAULT_IN [*2] |=> !FAULT_MSG_OUT
		&& FAULT_VALUE_OUT == 10'h000) else $error("fault shown without fault");
	a_unmapped_zero: assert property (PSEL_IN && PENABLE_IN && !PWRITE_IN
		&& PADDR_IN == 12'h020 |-> PRDATA_OUT == 32'h0000_0000) else $error("unmapped read");
endmodule // alarm_relay_props
bind alarm_relay alarm_relay_props props_i (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PREADY_OUT(PREADY_OUT),
	.PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .TEMP_IN(TEMP_IN),
	.FAULT_VALUE_OUT(FAULT_VALUE_OUT), .TEMP_VALID_IN(TEMP_VALID_IN),
	.SENSOR_FAULT_IN(SENSOR_FAULT_IN), .RELAY_CLOSED_OUT(RELAY_CLOSED_OUT),
	.BUZZER_OUT(BUZZER_OUT), .FAULT_MSG_OUT(FAULT_MSG_OUT));

// File: bench/temp_readout.sv
// temperature readout model: one-cycle samples and a sensor fault level
// assumes its tasks are called from a process synchronous to clk
`timescale 1ns/10ps
module temp_readout (
	input  logic       clk,
	output logic [9:0] temp_out,
	output logic       valid_out,
	output logic       fault_out
);
	initial begin
		temp_out = 10'h000;
		valid_out = 1'b0;
		fault_out = 1'b0;
	end
	// value scrambled after the strobe so a stale reading cannot pass by luck
	task sample(input logic [9:0] t);
		@(posedge clk);
		temp_out <= t;
		valid_out <= 1'b1;
		@(posedge clk);
		temp_out <= ~t;
		valid_out <= 1'b0;
	endtask
	task fault(input logic f);
		@(posedge clk);
		fault_out <= f;
	endtask
endmodule // temp_readout

// File: bench/alarm_relay_bench.sv
// self-checking bench: apb config, temperature samples, relay, beeper and fault display
// assumes alarm_relay, temp_readout and the bound checker; one second is 10 cycles here
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"
module alarm_relay_bench;
	localparam int SEC = 10;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, relay, buzz, endf, fmsg, tv, sf;
	logic [9:0]  fval, temp;
	int          num_errors = 0, n_tests = 0, rises, highs, rhighs;
	logic        seen_f;
	always #5 clk = ~clk;
	alarm_relay #(.SEC_CYCLES(SEC)) uut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TEMP_IN(temp),
		.TEMP_VALID_IN(tv), .SENSOR_FAULT_IN(sf), .RELAY_CLOSED_OUT(relay), .BUZZER_OUT(buzz),
		.END_FLASH_OUT(endf), .FAULT_MSG_OUT(fmsg), .FAULT_VALUE_OUT(fval));
	temp_readout probe (.clk(clk), .temp_out(temp), .valid_out(tv), .fault_out(sf));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// setup cycle, then access held until pready is sampled high
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task tsamp(input logic [9:0] t, input logic e);
		probe.sample(t);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(relay, e);
	endtask
	// counts tone onsets and high cycles on the negative edge, away from updates
	task watch(input int n);
		logic p;
		p = 1'b0;
		rises = 0;
		highs = 0;
		rhighs = 0;
		seen_f = 1'b0;
		repeat (n) begin
			@(negedge clk);
			rises += (buzz === 1'b1 && !p);
			highs += (buzz === 1'b1);
			rhighs += (relay === 1'b1);
			seen_f |= (endf === 1'b1);
			p = buzz;
		end
	endtask
	task ev(input int b, input int n);
		apb(`REG_EVENT, 1'b1, 32'h1 << b);
		watch(n);
	endtask
	task fault_look(input logic [31:0] c, input logic [9:0] v);
		logic m, s;
		m = 1'b0;
		s = 1'b0;
		apb(`REG_CTRL, 1'b1, c);
		repeat (6 * SEC) begin
			@(negedge clk);
			m |= fmsg === 1'b1;
			s |= fval === v;
		end
		chk({m, s}, 2'b11);
	endtask
	task end_sim;
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(`REG_CTRL, 1'b0, 32'h0);
		chk(rd, `CTRL_RESET);
		apb(`REG_HYST, 1'b0, 32'h0);
		chk(rd, 32'h003C_0003);
		apb(12'h020, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(pslverr, 1'b0);
		apb(`REG_LIMITS, 1'b1, 32'h00C8_0064);
		apb(`REG_CTRL, 1'b1, 32'h0000_0006);
		tsamp(10'd50, 1'b0);
		apb(`REG_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h0000_0012);
		tsamp(10'd103, 1'b0);
		tsamp(10'd99, 1'b0);
		tsamp(10'd104, 1'b0);
		tsamp(10'd99, 1'b1);
		apb(`REG_CTRL, 1'b1, 32'h0000_0002);
		tsamp(10'd104, 1'b0);
		tsamp(10'd101, 1'b0);
		tsamp(10'd99, 1'b1);
		tsamp(10'd102, 1'b1);
		tsamp(10'd104, 1'b0);
		apb(`REG_CTRL, 1'b1, 32'h0000_0003);
		tsamp(10'd150, 1'b0);
		tsamp(10'd99, 1'b1);
		tsamp(10'd150, 1'b0);
		apb(`REG_LIMITS, 1'b1, 32'h00C8_00C8);
		tsamp(10'd200, 1'b1);
		apb(`REG_LIMITS, 1'b1, 32'h00C8_0064);
		apb(`REG_CTRL, 1'b1, 32'h0000_0011);
		tsamp(10'd150, 1'b1);
		tsamp(10'd201, 1'b0);
		apb(`REG_CTRL, 1'b1, 32'h0000_0001);
		tsamp(10'd198, 1'b1);
		tsamp(10'd196, 1'b0);
		tsamp(10'd200, 1'b0);
		tsamp(10'd201, 1'b1);
		apb(`REG_CTRL, 1'b1, 32'h0000_0209);
		tsamp(10'd150, 1'b0);
		probe.sample(10'd201);
		watch(5 * SEC);
		chk(rhighs > SEC && rhighs <= 2 * SEC + 2, 1'b1);
		tsamp(10'd205, 1'b0);
		tsamp(10'd150, 1'b0);
		probe.sample(10'd201);
		watch(3 * SEC);
		chk(rhighs > 0, 1'b1);
		apb(`REG_CTRL, 1'b1, 32'h0000_7F00);
		apb(`REG_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h0000_6400);
		apb(`REG_CTRL, 1'b1, 32'h0000_0020);
		ev(`EV_STEP_START, 10 * SEC);
		chk(rises, 3);
		chk(highs > 2 * SEC && highs <= 3 * SEC, 1'b1);
		chk(rhighs, highs);
		ev(`EV_STEP_DONE, 20 * SEC);
		chk(rises, 4);
		chk(highs > 7 * SEC && highs <= 8 * SEC, 1'b1);
		ev(`EV_BOIL_START, 10 * SEC);
		chk(rises, 3);
		ev(`EV_PROG_END, 80 * SEC);
		chk(rises, 8);
		chk(seen_f, 1'b1);
		ev(`EV_BOIL_STOP, 3 * SEC);
		chk(endf, 1'b0);
		apb(`REG_HYST, 1'b1, 32'h0014_0003);
		ev(`EV_BOIL_EVENT, 40 * SEC);
		chk({rises > 4, buzz}, 2'b10);
		probe.fault(1'b1);
		fault_look(32'h0000_0040, `FAULT_F_VALUE);
		fault_look(32'h0000_0000, `FAULT_C_VALUE);
		probe.fault(1'b0);
		repeat (3) @(posedge clk);
		chk({fmsg, fval}, 11'h000);
		end_sim;
	end
endmodule // alarm_relay_bench
